// ==== rpts_params.svh ====
// constants of the ring poll timer and descriptor shadow register bank
`ifndef RPTS_PARAMS_SVH
`define RPTS_PARAMS_SVH
// Behaviour
// - current-rx register bits 11:0 copy the byte count of the rx count word.
// - current-tx register bits 31:24 copy bits 15:8 of the tx status word.
// - current-tx register bits 11:0 copy the byte count of the tx count word.
// - next-rx register bits 31:24 copy bits 15:8 of the rx status word.
// - next-rx register bits 11:0 copy the byte count of the rx count word.
// - reserved bits are written as zero by software; reads of them are meaningless.
// - shadow, poll and scratch registers are reachable only while stopped or suspended.
// - a 16-bit poll time counter counts up and triggers descriptor ring polls.
// - interval is two's complement of wait in half crystal periods; bits 3:0 ignored.
// - an implied bit 16 of one makes interval bit 15 a magnitude bit.
// - default interval value zero means 32,768 crystal periods between polls.
// - the default interval is set by initialization, not guaranteed right after reset.

// register byte offsets
`define RPTS_OFF_CUR_RX    5'h00
`define RPTS_OFF_CUR_TX    5'h04
`define RPTS_OFF_NXT_RX    5'h08
`define RPTS_OFF_POLL_CNT  5'h0C
`define RPTS_OFF_POLL_INT  5'h10
`define RPTS_OFF_SCR0      5'h14
`define RPTS_OFF_SCR1      5'h18
`define RPTS_OFF_CTRL      5'h1C
// control register bit positions
`define RPTS_CTRL_STOP     0
`define RPTS_CTRL_SUSPEND  1
`define RPTS_CTRL_START    2
`define RPTS_CTRL_INIT     3
// shadow register field positions
`define RPTS_STAT_MSB      31
`define RPTS_STAT_LSB      24
`define RPTS_WORD_STAT_MSB 15
`define RPTS_WORD_STAT_LSB 8
`define RPTS_COUNT_MSB     11
// interval field
`define RPTS_INT_MSB       15
`define RPTS_INT_IGN_BITS  4
// reset and default values
`define RPTS_STOP_RESET    1'b1
`define RPTS_SUSP_RESET    1'b0
`define RPTS_POLL_INT_RST  16'h0000
`define RPTS_POLL_INT_DEF  16'h0000
`define RPTS_POLL_CNT_RST  16'h0000
`define RPTS_POLL_CNT_TOP  16'hFFFF
// timing: system clock period, picoseconds
`define RPTS_CLK_PERIOD_PS 8000
`endif

// ==== rpts_pkg.sv ====
// types of the ring poll timer and descriptor shadow register bank
`default_nettype none
package rpts_pkg;
  // one descriptor snapshot as the dma engine presents it
  typedef struct packed {
    logic [15:0] status_word;
    logic [15:0] count_word;
  } rpts_desc_t;

  // one status and byte count shadow
  typedef struct packed {
    logic [7:0]  status;
    logic [11:0] count;
  } rpts_shadow_t;

  // registers of the bank
  typedef enum logic [3:0] {
    RPTS_R_CUR_RX, RPTS_R_CUR_TX, RPTS_R_NXT_RX, RPTS_R_POLL_CNT,
    RPTS_R_POLL_INT, RPTS_R_SCR0, RPTS_R_SCR1, RPTS_R_CTRL, RPTS_R_NONE
  } rpts_reg_t;

  // bus phase
  typedef enum logic {RPTS_PH_IDLE, RPTS_PH_READ} rpts_phase_t;

  // state of the bank apart from the scratch words
  typedef struct packed {
    rpts_phase_t        phase;
    logic               wr_pend;
    rpts_reg_t          wr_reg;
    rpts_reg_t          rd_reg;
    logic [31:0]        rdata;
    logic               readyout;
    rpts_shadow_t [2:0] shadow;
    logic [15:0]        poll_cnt;
    logic [15:0]        poll_int;
    logic [15:0]        div_cnt;
    logic               poll_req;
    logic               stop;
    logic               suspend;
  } rpts_state_t;
endpackage : rpts_pkg
`default_nettype wire

// ==== rpts_scratch_mem.sv ====
// small storage for the scratch words, registered read data
`timescale 1ns/1ps
`default_nettype none
module rpts_scratch_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock
  input  wire logic                     hclk,
  // write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // read port
  input  wire logic                     re,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end
endmodule : rpts_scratch_mem
`default_nettype wire

// ==== rpts_regs.sv ====
// descriptor shadow, poll timer and scratch registers behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "rpts_params.svh"
module rpts_regs #(
  parameter int ADDR_W         = 12,
  parameter int XTAL_PERIOD_PS = 50000
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [ADDR_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // descriptor snapshots: bit 0 cur rx, bit 1 cur tx, bit 2 next rx
  input  wire logic [2:0]           desc_load,
  input  wire rpts_pkg::rpts_desc_t desc_words,
  // polling and run state
  output logic                      ring_poll_req,
  output logic                      ctrl_stop,
  output logic                      ctrl_suspend
);
  import rpts_pkg::*;

  // half crystal period in clocks, rounded down, never below one
  localparam int HALF_RAW = (XTAL_PERIOD_PS / 2) / `RPTS_CLK_PERIOD_PS;
  localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : HALF_RAW;
  localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

  rpts_state_t st;
  rpts_state_t next_st;
  logic        allowed;
  logic        running;
  logic        tick;
  logic        accept;
  logic        mem_we;
  logic        mem_re;
  logic [31:0] mem_rdata;
  rpts_reg_t   addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  // byte address to register
  function automatic rpts_reg_t rpts_decode(input logic [ADDR_W-1:0] a);
    rpts_reg_t r;
    r = RPTS_R_NONE;
    if (a[ADDR_W-1:5] == '0)
    begin
      case (a[4:0])
        `RPTS_OFF_CUR_RX:   r = RPTS_R_CUR_RX;
        `RPTS_OFF_CUR_TX:   r = RPTS_R_CUR_TX;
        `RPTS_OFF_NXT_RX:   r = RPTS_R_NXT_RX;
        `RPTS_OFF_POLL_CNT: r = RPTS_R_POLL_CNT;
        `RPTS_OFF_POLL_INT: r = RPTS_R_POLL_INT;
        `RPTS_OFF_SCR0:     r = RPTS_R_SCR0;
        `RPTS_OFF_SCR1:     r = RPTS_R_SCR1;
        `RPTS_OFF_CTRL:     r = RPTS_R_CTRL;
        default:            r = RPTS_R_NONE;
      endcase
    end
    return r;
  endfunction : rpts_decode

  // shadow register as a bus word, reserved bits read zero
  function automatic logic [31:0] rpts_pack(input rpts_shadow_t s);
    return {s.status, 12'h000, s.count};
  endfunction : rpts_pack

  // register index of a shadow, used by reads and writes alike
  function automatic int rpts_shadow_idx(input rpts_reg_t r);
    case (r)
      RPTS_R_CUR_RX: return 0;
      RPTS_R_CUR_TX: return 1;
      default:       return 2;
    endcase
  endfunction : rpts_shadow_idx

  ////////////////////////////////////////////////////////////////////////////
  // bus strobes and gating

  // locked registers answer only while stopped or suspended
  assign allowed  = st.stop | st.suspend;
  assign running  = ~st.stop & ~st.suspend;
  assign tick     = (st.div_cnt == HALF_LAST);
  assign accept   = hsel & htrans[1] & hready;
  assign addr_reg = rpts_decode(haddr);
  assign mem_re   = accept & ~hwrite & (addr_reg == RPTS_R_SCR0 || addr_reg == RPTS_R_SCR1);
  assign mem_we   = st.wr_pend & allowed
                  & (st.wr_reg == RPTS_R_SCR0 || st.wr_reg == RPTS_R_SCR1);

  // scratch words
  rpts_scratch_mem #(
    .WIDTH (32),
    .DEPTH (2)
  ) u_scratch (
    .hclk  (hclk),
    .we    (mem_we),
    .waddr (st.wr_reg == RPTS_R_SCR1),
    .wdata (hwdata),
    .re    (mem_re),
    .raddr (addr_reg == RPTS_R_SCR1),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_st          = st;
    next_st.poll_req = 1'b0;
    // half crystal period divider, free running
    next_st.div_cnt  = tick ? 16'h0000 : st.div_cnt + 16'h0001;
    // write data phase
    if (st.wr_pend)
    begin
      next_st.wr_pend = 1'b0;
      if (st.wr_reg == RPTS_R_CTRL)
      begin
        next_st.stop    = hwdata[`RPTS_CTRL_STOP];
        next_st.suspend = hwdata[`RPTS_CTRL_SUSPEND];
        if (hwdata[`RPTS_CTRL_START])
        begin
          next_st.stop = 1'b0;
        end
        if (hwdata[`RPTS_CTRL_INIT])
        begin
          next_st.poll_int = `RPTS_POLL_INT_DEF;
          next_st.poll_cnt = `RPTS_POLL_INT_DEF;
        end
      end
      else if (allowed)
      begin
        case (st.wr_reg)
          RPTS_R_CUR_RX, RPTS_R_CUR_TX, RPTS_R_NXT_RX:
          begin
            // only the defined fields are kept
            next_st.shadow[rpts_shadow_idx(st.wr_reg)].status =
              hwdata[`RPTS_STAT_MSB:`RPTS_STAT_LSB];
            next_st.shadow[rpts_shadow_idx(st.wr_reg)].count = hwdata[`RPTS_COUNT_MSB:0];
          end
          RPTS_R_POLL_CNT: next_st.poll_cnt = hwdata[15:0];
          RPTS_R_POLL_INT: next_st.poll_int = hwdata[`RPTS_INT_MSB:0];
          default: next_st.wr_pend = 1'b0;
        endcase
      end
    end
    // descriptor snapshots win over software writes
    for (int i = 0; i < 3; i++)
    begin
      if (desc_load[i])
      begin
        next_st.shadow[i].status =
          desc_words.status_word[`RPTS_WORD_STAT_MSB:`RPTS_WORD_STAT_LSB];
        next_st.shadow[i].count  = desc_words.count_word[`RPTS_COUNT_MSB:0];
      end
    end
    // poll time counter, implied bit 16 set: carry out of 16 bits ends the wait
    if (running && tick)
    begin
      if (st.poll_cnt == `RPTS_POLL_CNT_TOP)
      begin
        next_st.poll_req = 1'b1;
        next_st.poll_cnt = {st.poll_int[`RPTS_INT_MSB:`RPTS_INT_IGN_BITS],
                            `RPTS_INT_IGN_BITS'(0)};
      end
      else
      begin
        next_st.poll_cnt = st.poll_cnt + 16'h0001;
      end
    end
    // read data phase: one wait state, then the word
    case (st.phase)
      RPTS_PH_READ:
      begin
        next_st.phase    = RPTS_PH_IDLE;
        next_st.readyout = 1'b1;
        next_st.rdata    = 32'h0000_0000;
        if (st.rd_reg == RPTS_R_CTRL)
        begin
          next_st.rdata[`RPTS_CTRL_STOP]    = st.stop;
          next_st.rdata[`RPTS_CTRL_SUSPEND] = st.suspend;
        end
        else if (allowed)
        begin
          case (st.rd_reg)
            RPTS_R_CUR_RX, RPTS_R_CUR_TX, RPTS_R_NXT_RX:
              next_st.rdata = rpts_pack(st.shadow[rpts_shadow_idx(st.rd_reg)]);
            RPTS_R_POLL_CNT: next_st.rdata = {16'h0000, st.poll_cnt};
            RPTS_R_POLL_INT: next_st.rdata = {16'h0000, st.poll_int};
            RPTS_R_SCR0, RPTS_R_SCR1: next_st.rdata = mem_rdata;
            default: next_st.rdata = 32'h0000_0000;
          endcase
        end
      end
      default:
      begin
        if (accept)
        begin
          if (hwrite)
          begin
            next_st.wr_pend = 1'b1;
            next_st.wr_reg  = addr_reg;
          end
          else
          begin
            next_st.phase    = RPTS_PH_READ;
            next_st.readyout = 1'b0;
            next_st.rd_reg   = addr_reg;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st          <= '0;
      st.phase    <= RPTS_PH_IDLE;
      st.wr_reg   <= RPTS_R_NONE;
      st.rd_reg   <= RPTS_R_NONE;
      st.readyout <= 1'b1;
      st.poll_cnt <= `RPTS_POLL_CNT_RST;
      st.poll_int <= `RPTS_POLL_INT_RST;
      st.stop     <= `RPTS_STOP_RESET;
      st.suspend  <= `RPTS_SUSP_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops, hresp tied to zero
  assign hrdata        = st.rdata;
  assign hreadyout     = st.readyout;
  assign hresp         = 1'b0;
  assign ring_poll_req = st.poll_req;
  assign ctrl_stop     = st.stop;
  assign ctrl_suspend  = st.suspend;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // descriptor copies into the shadows
  a_rx_count_copy: assert property (desc_load[0] |=>
    st.shadow[0].count == $past(desc_words.count_word[11:0]))
    else $error("current rx byte count not copied");
  a_tx_status_copy: assert property (desc_load[1] |=>
    st.shadow[1].status == $past(desc_words.status_word[15:8]))
    else $error("current tx status not copied");
  a_tx_count_copy: assert property (desc_load[1] |=>
    st.shadow[1].count == $past(desc_words.count_word[11:0]))
    else $error("current tx byte count not copied");
  a_nrx_status_copy: assert property (desc_load[2] |=>
    st.shadow[2].status == $past(desc_words.status_word[15:8]))
    else $error("next rx status not copied");
  a_nrx_count_copy: assert property (desc_load[2] |=>
    st.shadow[2].count == $past(desc_words.count_word[11:0]))
    else $error("next rx byte count not copied");

  // read words: a read returns the register as it stood during the wait state
  a_rx_read_word: assert property (
    st.phase == RPTS_PH_READ && allowed && st.rd_reg == RPTS_R_CUR_RX
    |=> hrdata == {$past(st.shadow[0].status), 12'h000, $past(st.shadow[0].count)})
    else $error("current rx shadow read wrong");
  a_tx_read_word: assert property (
    st.phase == RPTS_PH_READ && allowed && st.rd_reg == RPTS_R_CUR_TX
    |=> hrdata == {$past(st.shadow[1].status), 12'h000, $past(st.shadow[1].count)})
    else $error("current tx shadow read wrong");
  a_nrx_read_word: assert property (
    st.phase == RPTS_PH_READ && allowed && st.rd_reg == RPTS_R_NXT_RX
    |=> hrdata == {$past(st.shadow[2].status), 12'h000, $past(st.shadow[2].count)})
    else $error("next rx shadow read wrong");
  a_int_read_word: assert property (
    st.phase == RPTS_PH_READ && allowed && st.rd_reg == RPTS_R_POLL_INT
    |=> hrdata == {16'h0000, $past(st.poll_int)})
    else $error("interval read wrong");

  // reserved bits and access gating
  a_resv_read_zero: assert property (
    st.phase == RPTS_PH_READ && st.rd_reg inside {RPTS_R_CUR_RX, RPTS_R_CUR_TX}
    |=> hreadyout && hrdata[23:12] == 12'h000)
    else $error("reserved shadow bits not zero");
  a_locked_no_write: assert property (
    st.wr_pend && !allowed && st.wr_reg == RPTS_R_POLL_INT |=> $stable(st.poll_int))
    else $error("interval written while running");
  a_locked_read_zero: assert property (
    st.phase == RPTS_PH_READ && !allowed && st.rd_reg == RPTS_R_SCR0 |=> hrdata == 32'h0)
    else $error("scratch read while running");
  a_shadow_locked: assert property (
    st.wr_pend && !allowed && st.wr_reg inside {RPTS_R_CUR_RX, RPTS_R_CUR_TX, RPTS_R_NXT_RX}
    && desc_load == 3'h0 |=> $stable(st.shadow))
    else $error("shadow written while running");
  a_count_write: assert property (
    st.wr_pend && allowed && st.wr_reg == RPTS_R_POLL_CNT
    |=> st.poll_cnt == $past(hwdata[15:0]))
    else $error("poll counter write lost");
  a_int_write: assert property (
    st.wr_pend && allowed && st.wr_reg == RPTS_R_POLL_INT
    |=> st.poll_int == $past(hwdata[15:0]))
    else $error("interval write lost");

  // poll time counter: it moves only on a divider tick while running or on a bus write, and
  // a reload keeps the ignored low bits of the interval clear
  a_stopped_hold: assert property (
    !running && !st.wr_pend |=> $stable(st.poll_cnt))
    else $error("poll counter moved while stopped");
  a_poll_after_top: assert property (
    ring_poll_req |-> $past(st.poll_cnt) == 16'hFFFF)
    else $error("poll started without carry out");
  a_count_step: assert property (
    running && tick && st.poll_cnt != 16'hFFFF && !st.wr_pend
    |=> st.poll_cnt == $past(st.poll_cnt) + 16'h0001 && !ring_poll_req)
    else $error("poll counter did not step");
  a_poll_wrap: assert property (
    running && tick && st.poll_cnt == 16'hFFFF && !st.wr_pend
    |=> ring_poll_req && st.poll_cnt == {$past(st.poll_int[15:4]), 4'h0})
    else $error("poll not started on carry out");
  a_low_bits_clear: assert property (ring_poll_req |-> st.poll_cnt[3:0] == 4'h0)
    else $error("interval low bits not ignored");
  a_init_default: assert property (
    st.wr_pend && st.wr_reg == RPTS_R_CTRL && hwdata[3] |=> st.poll_int == 16'h0000)
    else $error("init did not load default interval");
  a_poll_pulse: assert property (ring_poll_req |=> !ring_poll_req [*1])
    else $error("poll request longer than one cycle");

  // main scenarios
  c_poll_start: cover property (ring_poll_req);
  c_read_done:  cover property (st.phase == RPTS_PH_READ ##1 hreadyout);
  c_int_write:  cover property (st.wr_pend && allowed && st.wr_reg == RPTS_R_POLL_INT);
  c_init:       cover property (st.wr_pend && st.wr_reg == RPTS_R_CTRL && hwdata[3]);
  c_lock_write: cover property (st.wr_pend && !allowed && st.wr_reg == RPTS_R_POLL_INT);
endmodule : rpts_regs
`default_nettype wire

// ==== rpts_regs_test.sv ====
// self-checking testbench of the descriptor shadow and ring poll timer bank
`timescale 1ns/1ps
`default_nettype none
`include "rpts_params.svh"
module rpts_regs_test;
  import rpts_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] A_CUR_RX = 12'(`RPTS_OFF_CUR_RX);
  localparam logic [11:0] A_CUR_TX = 12'(`RPTS_OFF_CUR_TX);
  localparam logic [11:0] A_CNT    = 12'(`RPTS_OFF_POLL_CNT);
  localparam logic [11:0] A_INT    = 12'(`RPTS_OFF_POLL_INT);
  localparam logic [11:0] A_SCR0   = 12'(`RPTS_OFF_SCR0);
  localparam logic [11:0] A_SCR1   = 12'(`RPTS_OFF_SCR1);
  localparam logic [11:0] A_CTRL   = 12'(`RPTS_OFF_CTRL);
  localparam logic [31:0] SHD_MASK = 32'hFF000FFF;
  // clock, reset and bus
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  wire logic   hready;
  // descriptor side and run state
  logic [2:0]  desc_load;
  rpts_desc_t  desc_words;
  logic        ring_poll_req;
  logic        ctrl_stop;
  logic        ctrl_suspend;
  int          n_errors;
  int          compares;
  assign hready = hreadyout;
  ////////////////////////////////////////////////////////////////////////////////
  // one-clock poll ticks keep the poll periods short
  rpts_regs #(.ADDR_W(12), .XTAL_PERIOD_PS(16000)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .desc_load(desc_load),
    .desc_words(desc_words), .ring_poll_req(ring_poll_req), .ctrl_stop(ctrl_stop),
    .ctrl_suspend(ctrl_suspend)
  );
  // 125 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // masked comparison of a value
  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got, input logic [31:0] mask);
    compares++;
    if ((got & mask) !== (exp & mask))
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp & mask, got & mask);
    end
  endtask : check_val
  // comparison against a window of values
  task automatic check_range(input string what, input int lo, input int hi,
                             input logic [31:0] got);
    compares++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      n_errors++;
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range
  // one single ahb-lite transfer, waiting on hready in both phases
  task automatic ahb_xfer(input logic wr, input logic [11:0] addr,
                          input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= addr;
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdat;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 128);
    rdat = hrdata;
    check_val("bus ready", 32'h0, {31'h0, n >= 128}, 32'h1);
    check_val("bus response", 32'h0, {31'h0, hresp}, 32'h1);
  endtask : ahb_xfer
  task automatic wr(input logic [11:0] addr, input logic [31:0] d);
    logic [31:0] unused;
    ahb_xfer(1'b1, addr, d, unused);
  endtask : wr
  // read one register and compare it
  task automatic rd_chk(input string what, input logic [11:0] addr,
                        input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] d;
    ahb_xfer(1'b0, addr, 32'h0, d);
    check_val(what, exp, d, mask);
  endtask : rd_chk
  // clocks up to and including the next poll pulse
  task automatic wait_poll(input int limit, output int n);
    n = 0;
    do begin @(posedge hclk); n++; end while (ring_poll_req !== 1'b1 && n < limit);
  endtask : wait_poll
  ////////////////////////////////////////////////////////////////////////////////
  // descriptor snapshots land in the three shadows
  task automatic t_shadow();
    logic [15:0] st [3];
    logic [15:0] ct [3];
    st = '{16'h81C3, 16'h7E24, 16'hC955};
    ct = '{16'hF123, 16'h0ABC, 16'h3FFF};
    for (int i = 0; i < 3; i++)
    begin
      desc_load  <= 3'(1 << i);
      desc_words <= '{status_word: st[i], count_word: ct[i]};
      @(posedge hclk);
      desc_load  <= 3'h0;
      rd_chk("shadow", A_CUR_RX + 12'(4 * i), {st[i][15:8], 12'h0, ct[i][11:0]}, SHD_MASK);
    end
    wr(A_CUR_TX, 32'h5A000321);
    rd_chk("shadow write", A_CUR_TX, 32'h5A000321, SHD_MASK);
  endtask : t_shadow
  // access only while stopped or suspended
  task automatic t_access();
    rd_chk("control reset", A_CTRL, 32'h1, 32'h3);
    wr(A_SCR0, 32'hA5C30F96);
    wr(A_SCR1, 32'h01234567);
    rd_chk("scratch0", A_SCR0, 32'hA5C30F96, 32'hFFFFFFFF);
    rd_chk("scratch1", A_SCR1, 32'h01234567, 32'hFFFFFFFF);
    wr(A_CTRL, 32'h4);
    @(posedge hclk);
    check_val("stop", 32'h0, {31'h0, ctrl_stop}, 32'h1);
    wr(A_SCR0, 32'hFFFF0000);
    wr(A_INT, 32'h0000FFF0);
    wr(A_CUR_TX, 32'hFF000FFF);
    rd_chk("scratch0 running", A_SCR0, 32'h0, 32'hFFFFFFFF);
    wr(A_CTRL, 32'h2);
    @(posedge hclk);
    check_val("suspend", 32'h1, {31'h0, ctrl_suspend}, 32'h1);
    rd_chk("scratch0 suspended", A_SCR0, 32'hA5C30F96, 32'hFFFFFFFF);
    rd_chk("shadow locked", A_CUR_TX, 32'h5A000321, SHD_MASK);
    wr(A_CTRL, 32'h1);
    rd_chk("interval locked", A_INT, 32'h0, 32'h0000FFFF);
    wr(12'h020, 32'hFFFFFFFF);
    rd_chk("unmapped", 12'h020, 32'h0, 32'hFFFFFFFF);
  endtask : t_access
  // counter runs only while started
  task automatic t_count();
    logic [31:0] d;
    wr(A_CNT, 32'h00000100);
    wr(A_CTRL, 32'h4);
    repeat (40) @(posedge hclk);
    wr(A_CTRL, 32'h1);
    ahb_xfer(1'b0, A_CNT, 32'h0, d);
    check_range("poll counter", 32'h100 + 38, 32'h100 + 48, d);
    rd_chk("poll counter held", A_CNT, d, 32'h0000FFFF);
  endtask : t_count
  // poll period from the interval, low nibble ignored, bit 15 a magnitude
  task automatic t_poll(input logic [15:0] intv, input int period);
    int n;
    wr(A_INT, {16'h0, intv});
    rd_chk("interval", A_INT, {16'h0, intv}, 32'h0000FFF0);
    wr(A_CNT, 32'h0000FFFA);
    rd_chk("counter preload", A_CNT, 32'h0000FFFA, 32'h0000FFFF);
    wr(A_CTRL, 32'h4);
    wait_poll(40, n);
    check_range("first poll", 1, 39, n);
    wait_poll(period + 8, n);
    check_val("poll period", period, n, 32'hFFFFFFFF);
    @(posedge hclk);
    check_val("poll pulse width", 32'h0, {31'h0, ring_poll_req}, 32'h1);
    wr(A_CTRL, 32'h1);
  endtask : t_poll
  // init restores the default interval
  task automatic t_init();
    wr(A_INT, 32'h00001230);
    rd_chk("interval user", A_INT, 32'h00001230, 32'h0000FFF0);
    // init with stop held, so the defaults can be read back
    wr(A_CTRL, 32'h9);
    rd_chk("interval default", A_INT, 32'h0, 32'h0000FFFF);
    rd_chk("counter init", A_CNT, 32'h0, 32'h0000FFFF);
  endtask : t_init
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // main sequence
  initial
  begin
    n_errors   = 0;
    compares   = 0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 12'h000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0;
    desc_load  = 3'h0;
    desc_words = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_val("reset stop", 32'h1, {31'h0, ctrl_stop}, 32'h1);
    check_val("reset poll", 32'h0, {31'h0, ring_poll_req}, 32'h1);
    t_shadow();
    t_access();
    t_count();
    t_poll(16'hFFF7, 16);
    t_poll(16'h8000, 32768);
    t_init();
    give_verdict();
  end
  // watchdog against a hung wait
  initial
  begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    give_verdict();
  end
endmodule : rpts_regs_test
`default_nettype wire
